//--- rtl/vdec_ctrl_map.svh
`ifndef VDEC_CTRL_MAP_SVH
`define VDEC_CTRL_MAP_SVH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define IDX_PORT_PIN_ROUTING 8'h0E
`define IDX_LUMA_GAIN_FILTER_CTRL 8'h0F
`define IDX_CONTRAST 8'h10
`define IDX_BRIGHTNESS 8'h11
`define IDX_CHROMA_CTRL_PRIMARY 8'h12
`define IDX_CHROMA_DELAY_PHASE_CTRL 8'h13

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_PORT_PIN_ROUTING 8'h00
`define RST_LUMA_GAIN_FILTER_CTRL 8'h00
`define RST_CONTRAST 8'h00
`define RST_BRIGHTNESS 8'h00
`define RST_CHROMA_CTRL_PRIMARY 8'h08
`define RST_CHROMA_DELAY_PHASE_CTRL 8'h00

// ----------------------------------------------------------------------
// field positions of port_pin_routing
// ----------------------------------------------------------------------
`define POS_PORT_A_SEL_LSB 0
`define POS_PORT_A_DIR 3
`define POS_PORT_B_SEL_LSB 4
`define POS_PORT_B_DIR 7

// ----------------------------------------------------------------------
// field positions of luma_gain_filter_ctrl
// ----------------------------------------------------------------------
`define POS_PEAK_LSB 0
`define POS_NOTCH 2
`define POS_BW_REDUCE 3
`define POS_PEDESTAL 4
`define POS_FULL_RANGE 5
`define POS_UNITY 6

// ----------------------------------------------------------------------
// field positions of the chroma registers
// ----------------------------------------------------------------------
`define POS_KILL_LSB 0
`define POS_CORE_LSB 2
`define POS_CBW 4
`define POS_N_VARIANT 5
`define POS_M_VARIANT 6
`define POS_GAIN_FREEZE 7
`define POS_PHASE_LSB 0
`define POS_DELAY_LSB 4

// ----------------------------------------------------------------------
// fixed codes
// ----------------------------------------------------------------------
`define CHROMA_NEUTRAL 8'h80
`define INPUT_SEL_DIGITAL_601 2'h1
`define READ_UNMAPPED 8'h00

`endif

//--- rtl/vdec_ctrl_pkg.sv
package vdec_ctrl_pkg;
  // colour kill settings
  typedef enum logic [1:0] {
    KILL_AUTO = 2'h0,
    KILL_RSVD = 2'h1,
    KILL_NEVER = 2'h2,
    KILL_ALWAYS = 2'h3
  } kill_mode_e;
  // chroma coring settings
  typedef enum logic [1:0] {
    CORE_OFF = 2'h0,
    CORE_PM1 = 2'h1,
    CORE_PM3 = 2'h2,
    CORE_PM7 = 2'h3
  } core_mode_e;
  typedef logic [7:0] byte_t;
endpackage

//--- rtl/video_decoder_port_luma_chroma_ctrl.sv
`include "vdec_ctrl_map.svh"

// What this block does
// - port A select picks one of seven gates
// - port A drives out, or pin replaces gate
// - port B select picks one of seven signals
// - port B value 7 gives serial control out
// - blanking flags mark raw and sliced lines
// - port B drives out, or pin replaces path
// - two-bit luma peaking level field
// - chroma notch in luma path when set
// - luma bandwidth reduce bit
// - pedestal bit moves black point to 7.5%
// - high gain gives full range luma codes
// - unity gain for 601 input needs both bits
// - contrast and brightness are signed bytes
// - colour kill auto, always on, always off
// - coring forces near-neutral chroma to 128
// - chroma bandwidth 850 or 550 kHz
// - N variant tracking select
// - M variant tracking select
// - chroma gain freeze holds current gain
// - burst phase compare in 22.5 degree steps
// - chroma group delay in pixel clocks
// - software bit permits output high impedance
// - group select chooses which pins float
module video_decoder_port_luma_chroma_ctrl
  import vdec_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // indexed register access
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // internal timing sources for port A (index 1..7)
  input wire logic back_porch_gate,
  input wire logic sync_tip_gate,
  input wire logic burst_gate,
  input wire logic burst_gate_wide,
  input wire logic mid_sync_marker,
  input wire logic vbi_flag,
  input wire logic general_purpose_pin_bit,
  // internal sources for port B (index 1..7)
  input wire logic sync_to_burst_phase,
  input wire logic twice_per_line_pulse,
  input wire logic sync_falling_edge_pulse,
  input wire logic blanking_raw_adc_flag,
  input wire logic blanking_sliced_flag,
  input wire logic vertical_sync,
  input wire logic realtime_control_serial_out,
  // port A pin
  input wire logic port_a_in,
  output logic port_a_out,
  output logic port_a_oe_n,
  // port B pin
  input wire logic port_b_in,
  output logic port_b_out,
  output logic port_b_oe_n,
  // paths into the decoder, after pin substitution
  output logic [7:1] port_a_path,
  output logic [7:1] port_b_path,
  // output float control
  input wire logic software_output_tristate,
  input wire logic output_enable_pin_n,
  input wire logic [1:0] tristate_group_select,
  // luma context
  input wire logic [1:0] input_source_select,
  output logic [1:0] luma_peaking_level,
  output logic chroma_notch_enable,
  output logic luma_bandwidth_reduce,
  output logic pedestal_gain_enable,
  output logic full_range_luma_gain,
  output logic luma_unity_gain,
  output logic [7:0] contrast_value,
  output logic [7:0] brightness_value,
  // chroma sample path
  input wire logic [7:0] chroma_in,
  input wire logic burst_weak,
  output logic [7:0] chroma_out,
  // chroma controls
  output logic chroma_bandwidth_select,
  output logic n_variant_tracking_select,
  output logic m_variant_tracking_select,
  output logic chroma_gain_freeze,
  output logic [3:0] burst_phase_compare,
  output logic [3:0] chroma_group_delay
);

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  byte_t port_pin_routing_reg; // port select and direction
  byte_t luma_gain_filter_ctrl_reg; // peaking, notch, gain bits
  byte_t contrast_reg; // signed contrast
  byte_t brightness_reg; // signed brightness
  byte_t chroma_ctrl_primary_reg; // kill, coring, bandwidth, tracking
  byte_t chroma_delay_phase_ctrl_reg; // phase compare and delay

  // software writes; reset restores the default of every field
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      port_pin_routing_reg <= `RST_PORT_PIN_ROUTING;
      luma_gain_filter_ctrl_reg <= `RST_LUMA_GAIN_FILTER_CTRL;
      contrast_reg <= `RST_CONTRAST;
      brightness_reg <= `RST_BRIGHTNESS;
      chroma_ctrl_primary_reg <= `RST_CHROMA_CTRL_PRIMARY;
      chroma_delay_phase_ctrl_reg <= `RST_CHROMA_DELAY_PHASE_CTRL;
    end else if (reg_write) begin
      case (reg_index)
        `IDX_PORT_PIN_ROUTING: port_pin_routing_reg <= reg_wdata;
        `IDX_LUMA_GAIN_FILTER_CTRL: luma_gain_filter_ctrl_reg <= reg_wdata;
        `IDX_CONTRAST: contrast_reg <= reg_wdata;
        `IDX_BRIGHTNESS: brightness_reg <= reg_wdata;
        `IDX_CHROMA_CTRL_PRIMARY: chroma_ctrl_primary_reg <= reg_wdata;
        `IDX_CHROMA_DELAY_PHASE_CTRL: chroma_delay_phase_ctrl_reg <= reg_wdata;
        default: begin
          // unmapped index: write is dropped
        end
      endcase
    end
  end

  // read data is registered one cycle after the read strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `READ_UNMAPPED;
    end else if (reg_read) begin
      case (reg_index)
        `IDX_PORT_PIN_ROUTING: reg_rdata <= port_pin_routing_reg;
        `IDX_LUMA_GAIN_FILTER_CTRL: reg_rdata <= luma_gain_filter_ctrl_reg;
        `IDX_CONTRAST: reg_rdata <= contrast_reg;
        `IDX_BRIGHTNESS: reg_rdata <= brightness_reg;
        `IDX_CHROMA_CTRL_PRIMARY: reg_rdata <= chroma_ctrl_primary_reg;
        `IDX_CHROMA_DELAY_PHASE_CTRL: reg_rdata <= chroma_delay_phase_ctrl_reg;
        default: reg_rdata <= `READ_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------------
  logic [2:0] port_a_source_select; // routing index for port A
  logic port_a_direction; // 1 drives the pin
  logic [2:0] port_b_source_select; // routing index for port B
  logic port_b_direction; // 1 drives the pin
  logic [7:0] src_a; // internal sources, bit 0 unused
  logic [7:0] src_b; // internal sources, bit 0 unused
  logic float_permit; // output floating allowed
  logic float_a; // port A group floated
  logic float_b; // port B group floated

  assign port_a_source_select = port_pin_routing_reg[`POS_PORT_A_SEL_LSB +: 3];
  assign port_a_direction = port_pin_routing_reg[`POS_PORT_A_DIR];
  assign port_b_source_select = port_pin_routing_reg[`POS_PORT_B_SEL_LSB +: 3];
  assign port_b_direction = port_pin_routing_reg[`POS_PORT_B_DIR];

  // index 0 is "no connection" and carries a constant low
  assign src_a = {general_purpose_pin_bit, vbi_flag, mid_sync_marker, burst_gate_wide,
                  burst_gate, sync_tip_gate, back_porch_gate, 1'b0};
  // raw and sliced blanking flags arrive already qualified per line
  assign src_b = {realtime_control_serial_out, vertical_sync, blanking_sliced_flag,
                  blanking_raw_adc_flag, sync_falling_edge_pulse, twice_per_line_pulse,
                  sync_to_burst_phase, 1'b0};

  // either the software bit or a low enable pin allows floating
  assign float_permit = software_output_tristate | ~output_enable_pin_n;
  assign float_a = float_permit & tristate_group_select[0];
  assign float_b = float_permit & tristate_group_select[1];

  // ----------------------------------------------------------------------
  // port pins
  // ----------------------------------------------------------------------
  // drive only when set as output and a source is selected; an input
  // port never fights the outside logic
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      port_a_out <= 1'b0;
      port_a_oe_n <= 1'b1;
      port_b_out <= 1'b0;
      port_b_oe_n <= 1'b1;
    end else begin
      port_a_out <= src_a[port_a_source_select];
      port_a_oe_n <= ~(port_a_direction & (port_a_source_select != 3'h0) & ~float_a);
      port_b_out <= src_b[port_b_source_select];
      port_b_oe_n <= ~(port_b_direction & (port_b_source_select != 3'h0) & ~float_b);
    end
  end

  // ----------------------------------------------------------------------
  // decoder paths with pin substitution
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 1; gi < 8; gi++) begin : g_path
      // as input, the pin replaces the selected path and the gate is cut off
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          port_a_path[gi] <= 1'b0;
          port_b_path[gi] <= 1'b0;
        end else begin
          if (!port_a_direction && port_a_source_select == 3'(gi)) begin
            port_a_path[gi] <= port_a_in;
          end else begin
            port_a_path[gi] <= src_a[gi];
          end
          if (!port_b_direction && port_b_source_select == 3'(gi)) begin
            port_b_path[gi] <= port_b_in;
          end else begin
            port_b_path[gi] <= src_b[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // luma controls
  // ----------------------------------------------------------------------
  // unity gain needs pedestal and high gain both set and 601 input
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      luma_peaking_level <= 2'h0;
      chroma_notch_enable <= 1'b0;
      luma_bandwidth_reduce <= 1'b0;
      pedestal_gain_enable <= 1'b0;
      full_range_luma_gain <= 1'b0;
      luma_unity_gain <= 1'b0;
      contrast_value <= 8'h00;
      brightness_value <= 8'h00;
    end else begin
      luma_peaking_level <= luma_gain_filter_ctrl_reg[`POS_PEAK_LSB +: 2];
      chroma_notch_enable <= luma_gain_filter_ctrl_reg[`POS_NOTCH];
      luma_bandwidth_reduce <= luma_gain_filter_ctrl_reg[`POS_BW_REDUCE];
      pedestal_gain_enable <= luma_gain_filter_ctrl_reg[`POS_PEDESTAL];
      full_range_luma_gain <= luma_gain_filter_ctrl_reg[`POS_FULL_RANGE];
      luma_unity_gain <= luma_gain_filter_ctrl_reg[`POS_UNITY]
                         & luma_gain_filter_ctrl_reg[`POS_PEDESTAL]
                         & luma_gain_filter_ctrl_reg[`POS_FULL_RANGE]
                         & (input_source_select == `INPUT_SEL_DIGITAL_601);
      contrast_value <= contrast_reg;
      brightness_value <= brightness_reg;
    end
  end

  // ----------------------------------------------------------------------
  // chroma kill and coring
  // ----------------------------------------------------------------------
  kill_mode_e kill_mode; // colour kill setting
  core_mode_e core_mode; // coring window setting
  logic kill_now; // force neutral this sample
  logic [7:0] centred; // sample minus 128, two's complement
  logic [7:0] magnitude; // distance from 128
  logic [7:0] core_limit; // 1, 3 or 7
  logic cored; // sample within coring window

  assign kill_mode = kill_mode_e'(chroma_ctrl_primary_reg[`POS_KILL_LSB +: 2]);
  assign core_mode = core_mode_e'(chroma_ctrl_primary_reg[`POS_CORE_LSB +: 2]);
  assign centred = chroma_in ^ `CHROMA_NEUTRAL;
  assign magnitude = centred[7] ? 8'(-centred) : centred;

  always_comb begin
    // the undefined kill code behaves like auto, the safest reading
    case (kill_mode)
      KILL_NEVER: kill_now = 1'b0;
      KILL_ALWAYS: kill_now = 1'b1;
      default: kill_now = burst_weak;
    endcase
    case (core_mode)
      CORE_PM1: core_limit = 8'h01;
      CORE_PM3: core_limit = 8'h03;
      CORE_PM7: core_limit = 8'h07;
      default: core_limit = 8'h00;
    endcase
  end

  assign cored = (core_mode != CORE_OFF) && (magnitude <= core_limit);

  // one stage of latency on the chroma samples
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chroma_out <= `CHROMA_NEUTRAL;
    end else if (kill_now || cored) begin
      chroma_out <= `CHROMA_NEUTRAL;
    end else begin
      chroma_out <= chroma_in;
    end
  end

  // ----------------------------------------------------------------------
  // chroma filter, tracking, freeze, phase and delay controls
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chroma_bandwidth_select <= 1'b0;
      n_variant_tracking_select <= 1'b0;
      m_variant_tracking_select <= 1'b0;
      chroma_gain_freeze <= 1'b0;
      burst_phase_compare <= 4'h0;
      chroma_group_delay <= 4'h0;
    end else begin
      chroma_bandwidth_select <= chroma_ctrl_primary_reg[`POS_CBW];
      n_variant_tracking_select <= chroma_ctrl_primary_reg[`POS_N_VARIANT];
      m_variant_tracking_select <= chroma_ctrl_primary_reg[`POS_M_VARIANT];
      chroma_gain_freeze <= chroma_ctrl_primary_reg[`POS_GAIN_FREEZE];
      burst_phase_compare <= chroma_delay_phase_ctrl_reg[`POS_PHASE_LSB +: 4];
      chroma_group_delay <= chroma_delay_phase_ctrl_reg[`POS_DELAY_LSB +: 4];
    end
  end

endmodule

//--- testbench/vdec_ctrl_asserts.sv
`include "vdec_ctrl_map.svh"

module vdec_ctrl_asserts
  import vdec_ctrl_pkg::*;
(
  // clock, reset and register port
  input wire logic clk_sys, nrst, reg_write, reg_read,
  input wire logic [7:0] reg_index, reg_wdata, reg_rdata,
  // port sources, pins and float control
  input wire logic back_porch_gate, sync_tip_gate, burst_gate, burst_gate_wide,
  input wire logic mid_sync_marker, vbi_flag, general_purpose_pin_bit,
  input wire logic sync_to_burst_phase, twice_per_line_pulse, sync_falling_edge_pulse,
  input wire logic blanking_raw_adc_flag, blanking_sliced_flag, vertical_sync,
  input wire logic realtime_control_serial_out, port_a_in, port_b_in,
  input wire logic port_a_out, port_a_oe_n, port_b_out, port_b_oe_n,
  input wire logic [7:1] port_a_path, port_b_path,
  input wire logic software_output_tristate, output_enable_pin_n,
  input wire logic [1:0] tristate_group_select,
  // luma and chroma
  input wire logic [1:0] input_source_select, luma_peaking_level,
  input wire logic chroma_notch_enable, luma_bandwidth_reduce, pedestal_gain_enable,
  input wire logic full_range_luma_gain, luma_unity_gain, burst_weak,
  input wire logic [7:0] contrast_value, brightness_value, chroma_in, chroma_out,
  input wire logic chroma_bandwidth_select, n_variant_tracking_select,
  input wire logic m_variant_tracking_select, chroma_gain_freeze,
  input wire logic [3:0] burst_phase_compare, chroma_group_delay
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // shadow of the register file and expected values
  // ----------
  byte_t sh [6];  // 0x0E..0x13
  byte_t rd_exp, lim, c_exp;
  logic [7:1] a_src, b_src, a_mix, b_mix;
  logic [2:0] a_sel, b_sel;
  logic mapped, a_on, b_on, perm, hit, kill;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // shadow follows writes to mapped indices only
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sh <= '{`RST_PORT_PIN_ROUTING, `RST_LUMA_GAIN_FILTER_CTRL, `RST_CONTRAST,
        `RST_BRIGHTNESS, `RST_CHROMA_CTRL_PRIMARY, `RST_CHROMA_DELAY_PHASE_CTRL};
    end else if (reg_write && mapped) begin
      sh[reg_index - `IDX_PORT_PIN_ROUTING] <= reg_wdata;
    end
  end
  // what pins, paths and chroma should show for the current inputs
  always_comb begin
    mapped = reg_index >= `IDX_PORT_PIN_ROUTING && reg_index <= `IDX_CHROMA_DELAY_PHASE_CTRL;
    rd_exp = mapped ? sh[reg_index - `IDX_PORT_PIN_ROUTING] : `READ_UNMAPPED;
    a_src = {general_purpose_pin_bit, vbi_flag, mid_sync_marker, burst_gate_wide, burst_gate,
      sync_tip_gate, back_porch_gate};
    b_src = {realtime_control_serial_out, vertical_sync, blanking_sliced_flag,
      blanking_raw_adc_flag, sync_falling_edge_pulse, twice_per_line_pulse, sync_to_burst_phase};
    a_sel = sh[0][2:0];
    b_sel = sh[0][6:4];
    perm = software_output_tristate || !output_enable_pin_n;
    a_on = sh[0][3] && a_sel != 3'h0 && !(perm && tristate_group_select[0]);
    b_on = sh[0][7] && b_sel != 3'h0 && !(perm && tristate_group_select[1]);
    a_mix = a_src;
    b_mix = b_src;
    // input mode: the pin takes the place of the selected source
    if (!sh[0][3] && a_sel != 3'h0) begin
      a_mix[a_sel] = port_a_in;
    end
    if (!sh[0][7] && b_sel != 3'h0) begin
      b_mix[b_sel] = port_b_in;
    end
    lim = (8'h01 << sh[4][3:2]) - 8'h01;
    hit = sh[4][3:2] != 2'h0 && chroma_in >= 8'h80 - lim && chroma_in <= 8'h80 + lim;
    kill = sh[4][1:0] == 2'h3 || (!sh[4][1] && burst_weak);
    c_exp = (kill || hit) ? `CHROMA_NEUTRAL : chroma_in;
  end
  // a register that held its value across two edges
  sequence s_hold(byte_t x);
    1 ##1 $stable(x);
  endsequence
  AST_RDATA: assert property (reg_read |=> reg_rdata == $past(rd_exp))
    else $error("read data not the register contents");
  AST_PORT_A: assert property (s_hold(sh[0]) |=>
    port_a_oe_n == $past(!a_on) && port_a_path == $past(a_mix))
    else $error("port A enable or path wrong");
  AST_PORT_A_OUT: assert property (s_hold(sh[0]) ##0 a_on |=>
    port_a_out == $past(a_src[a_sel]))
    else $error("port A drives wrong source");
  AST_PORT_B: assert property (s_hold(sh[0]) |=>
    port_b_oe_n == $past(!b_on) && port_b_path == $past(b_mix))
    else $error("port B enable or path wrong");
  AST_PORT_B_OUT: assert property (s_hold(sh[0]) ##0 b_on |=>
    port_b_out == $past(b_src[b_sel]))
    else $error("port B drives wrong source");
  AST_CHROMA: assert property (s_hold(sh[4]) |=> chroma_out == $past(c_exp))
    else $error("chroma kill or coring wrong");
  AST_LUMA_FIELDS: assert property (s_hold(sh[1]) |-> {full_range_luma_gain,
    pedestal_gain_enable, luma_bandwidth_reduce, chroma_notch_enable, luma_peaking_level}
    == sh[1][5:0])
    else $error("luma field outputs wrong");
  AST_UNITY: assert property (s_hold(sh[1]) ##0 $stable(input_source_select) |->
    luma_unity_gain == (sh[1][6] && sh[1][5] && sh[1][4] &&
    input_source_select == `INPUT_SEL_DIGITAL_601))
    else $error("unity gain wrong");
  AST_LEVELS: assert property (s_hold(sh[2]) ##0 $stable(sh[3]) |->
    contrast_value == sh[2] && brightness_value == sh[3])
    else $error("contrast or brightness wrong");
  AST_CHROMA_FIELDS: assert property (s_hold(sh[4]) ##0 $stable(sh[5]) |->
    {chroma_gain_freeze, m_variant_tracking_select, n_variant_tracking_select,
    chroma_bandwidth_select} == sh[4][7:4] && {chroma_group_delay, burst_phase_compare} == sh[5])
    else $error("chroma field outputs wrong");
endmodule

bind video_decoder_port_luma_chroma_ctrl vdec_ctrl_asserts vdec_ctrl_asserts_inst (.*);

//--- testbench/vdec_pin_partner.sv
module vdec_pin_partner (
  // bench commands for the outside logic
  input wire logic clk_sys,
  input wire logic drv_a, drv_b, ext_a, ext_b,
  // device side of both pins
  input wire logic port_a_out, port_a_oe_n, port_b_out, port_b_oe_n,
  output logic port_a_in,
  output logic port_b_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // no pull on these pins, so an undriven pin shows a changing level
  logic flip_reg = 1'b0;
  always_ff @(posedge clk_sys) begin
    flip_reg <= !flip_reg;
  end
  // wire level: the device when it drives, else outside logic, else floating
  always_comb begin
    port_a_in = !port_a_oe_n ? port_a_out : (drv_a ? ext_a : flip_reg);
    port_b_in = !port_b_oe_n ? port_b_out : (drv_b ? ext_b : flip_reg);
  end
endmodule

//--- testbench/video_decoder_port_luma_chroma_ctrl_bench.sv
`include "vdec_ctrl_map.svh"

module video_decoder_port_luma_chroma_ctrl_bench
  import vdec_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // signals, named as the ports they meet
  // ----------
  logic clk_sys = 1'b0;
  logic nrst = 1'b0, reg_write = 1'b0, reg_read = 1'b0, burst_weak = 1'b0;
  logic drv_a = 1'b0, drv_b = 1'b0, ext_a = 1'b0, ext_b = 1'b0, cw;
  logic software_output_tristate = 1'b0, output_enable_pin_n = 1'b1;
  logic [1:0] tristate_group_select = 2'h0, input_source_select = 2'h1;
  byte_t reg_index = 8'h00, reg_wdata = 8'h00, chroma_in = 8'h00, cr, ce;
  logic [6:0] src_a = 7'h00, src_b = 7'h00, oh;  // source i sits at bit i-1
  logic back_porch_gate, sync_tip_gate, burst_gate, burst_gate_wide, mid_sync_marker;
  logic vbi_flag, general_purpose_pin_bit, sync_to_burst_phase, twice_per_line_pulse;
  logic sync_falling_edge_pulse, blanking_raw_adc_flag, blanking_sliced_flag, vertical_sync;
  logic realtime_control_serial_out, port_a_in, port_a_out, port_a_oe_n, port_b_in;
  logic port_b_out, port_b_oe_n, chroma_notch_enable, luma_bandwidth_reduce, luma_unity_gain;
  logic pedestal_gain_enable, full_range_luma_gain, chroma_bandwidth_select;
  logic n_variant_tracking_select, m_variant_tracking_select, chroma_gain_freeze;
  logic [1:0] luma_peaking_level;
  logic [3:0] burst_phase_compare, chroma_group_delay;
  logic [7:1] port_a_path, port_b_path;
  byte_t reg_rdata, contrast_value, brightness_value, chroma_out;
  byte_t rst_tab [6] = '{`RST_PORT_PIN_ROUTING, `RST_LUMA_GAIN_FILTER_CTRL, `RST_CONTRAST,
    `RST_BRIGHTNESS, `RST_CHROMA_CTRL_PRIMARY, `RST_CHROMA_DELAY_PHASE_CTRL};
  // chroma cases: control byte, weak burst, sample in, sample out
  logic [24:0] ch_tab [13] = '{{8'h00, 1'b1, 8'h30, 8'h80}, {8'h00, 1'b0, 8'h30, 8'h30},
    {8'h02, 1'b1, 8'h30, 8'h30}, {8'h03, 1'b0, 8'h30, 8'h80}, {8'h06, 1'b0, 8'h81, 8'h80},
    {8'h06, 1'b0, 8'h82, 8'h82}, {8'h0A, 1'b0, 8'h7D, 8'h80}, {8'h0A, 1'b0, 8'h7C, 8'h7C},
    {8'h0E, 1'b0, 8'h87, 8'h80}, {8'h0E, 1'b0, 8'h88, 8'h88}, {8'h0E, 1'b0, 8'h79, 8'h80},
    {8'h02, 1'b0, 8'h7F, 8'h7F}, {8'h01, 1'b1, 8'h30, 8'h80}};
  int n_fail = 0, compares = 0;
  assign {general_purpose_pin_bit, vbi_flag, mid_sync_marker, burst_gate_wide, burst_gate,
    sync_tip_gate, back_porch_gate} = src_a;
  assign {realtime_control_serial_out, vertical_sync, blanking_sliced_flag,
    blanking_raw_adc_flag, sync_falling_edge_pulse, twice_per_line_pulse,
    sync_to_burst_phase} = src_b;
  video_decoder_port_luma_chroma_ctrl video_decoder_port_luma_chroma_ctrl_inst (.*);
  vdec_pin_partner vdec_pin_partner_inst (.*);
  // ----------
  // clock, tasks and verdict
  // ----------
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // inputs move 10 ns after the edge, well clear of sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  task automatic chk(input byte_t got, input byte_t exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one strobe cycle, then one idle cycle so strobes never merge
  task automatic wr(input byte_t idx, input byte_t d);
    reg_index = idx;
    reg_wdata = d;
    reg_write = 1'b1;
    tick(1);
    reg_write = 1'b0;
    tick(1);
  endtask
  task automatic rd(input byte_t idx, input byte_t exp);
    reg_index = idx;
    reg_read = 1'b1;
    tick(1);
    reg_read = 1'b0;
    chk(reg_rdata, exp);
    tick(1);
  endtask
  task automatic flt(input logic sw, input logic output_enable_pin, input logic [1:0] g, input byte_t exp);
    software_output_tristate = sw;
    output_enable_pin_n = output_enable_pin;
    tristate_group_select = g;
    tick(2);
    chk(8'({port_a_oe_n, port_b_oe_n}), exp);
  endtask
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard: the sequence needs only about two hundred cycles
  initial begin
    #2000000;
    n_fail++;
    final_report();
  end
  initial begin
    tick(10);
    nrst = 1'b1;
    chk(8'({port_a_oe_n, port_b_oe_n}), 8'h03);
    for (int i = 0; i < 6; i++) rd(8'(8'h0E + i), rst_tab[i]);
    $display("test reset done");
    // every register, plus two unmapped writes that must be dropped
    for (int i = 0; i < 6; i++) wr(8'(8'h0E + i), 8'(8'h5A ^ i));
    wr(8'h0D, 8'hFF);
    wr(8'h14, 8'hFF);
    for (int i = 0; i < 6; i++) rd(8'(8'h0E + i), 8'(8'h5A ^ i));
    rd(8'h14, `READ_UNMAPPED);
    chk(contrast_value, 8'h58);
    chk(brightness_value, 8'h59);
    chk(8'({chroma_gain_freeze, m_variant_tracking_select}), 8'h01);
    chk(8'({n_variant_tracking_select, chroma_bandwidth_select}), 8'h01);
    chk({chroma_group_delay, burst_phase_compare}, 8'h5F);
    $display("test registers done");
    for (int p = 0; p < 4; p++) begin
      wr(8'h0F, 8'(8'h7C | p));
      chk(8'(luma_peaking_level), 8'(p));
      chk(8'(luma_unity_gain), 8'h01);
    end
    input_source_select = 2'h2;
    tick(2);
    chk(8'(luma_unity_gain), 8'h00);
    input_source_select = 2'h1;
    wr(8'h0F, 8'h6F);
    chk(8'(luma_unity_gain), 8'h00);
    chk(8'({full_range_luma_gain, pedestal_gain_enable, luma_bandwidth_reduce,
      chroma_notch_enable}), 8'h0B);
    $display("test luma done");
    for (int s = 1; s < 8; s++) begin
      oh = 7'(7'h01 << (s - 1));
      wr(8'h0E, 8'(8'h88 | s << 4 | s));
      src_a = oh;
      src_b = oh;
      tick(2);
      chk(8'({port_a_oe_n, port_a_out, port_b_oe_n, port_b_out}), 8'h05);
      src_a = ~oh;
      src_b = ~oh;
      tick(2);
      chk(8'({port_a_oe_n, port_a_out, port_b_oe_n, port_b_out}), 8'h00);
      // input mode: the outside logic replaces the selected source
      wr(8'h0E, 8'(s << 4 | s));
      drv_a = 1'b1;
      drv_b = 1'b1;
      ext_a = 1'b1;
      ext_b = 1'b0;
      tick(2);
      chk(8'({port_a_oe_n, port_b_oe_n}), 8'h03);
      chk(8'(port_a_path), 8'h7F);
      chk(8'(port_b_path), {1'b0, ~oh});
    end
    $display("test ports done");
    wr(8'h0E, 8'h99);
    flt(1'b1, 1'b1, 2'h1, 8'h02);
    flt(1'b0, 1'b0, 2'h2, 8'h01);
    flt(1'b0, 1'b1, 2'h3, 8'h00);
    $display("test float done");
    for (int i = 0; i < 13; i++) begin
      {cr, cw, chroma_in, ce} = ch_tab[i];
      wr(`IDX_CHROMA_CTRL_PRIMARY, cr);
      burst_weak = cw;
      tick(2);
      chk(chroma_out, ce);
    end
    $display("test chroma done");
    final_report();
  end
endmodule
